// file: include/adcs_pkg.sv
// ***************************************************************
// Shared constants of the converter control sequencer
// ***************************************************************
package adcs_pkg;

    // ***********************************************************
    // Timing
    // ***********************************************************
    localparam int CLK_PERIOD_NS = 10;
    // Instruction cycle is four oscillator periods
    localparam int INSTR_CYCLE_NS = 40;
    localparam int INSTR_CLKS = (INSTR_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ***********************************************************
    // Register map (byte addresses, one word each)
    // ***********************************************************
    localparam logic [7:0] OFS_CTRL0 = 8'h00;
    localparam logic [7:0] OFS_CTRL1 = 8'h04;
    localparam logic [7:0] OFS_RES_HIGH = 8'h08;
    localparam logic [7:0] OFS_RES_LOW = 8'h0C;
    localparam logic [7:0] OFS_WDT_CTRL = 8'h10;
    localparam logic [7:0] OFS_STATUS = 8'h14;

    // ***********************************************************
    // Field positions
    // ***********************************************************
    localparam int B_NEG_REF = 7;
    localparam int B_POS_REF = 6;
    localparam int B_CHAN_HI = 5;
    localparam int B_CHAN_LO = 2;
    localparam int B_START = 1;
    localparam int B_ENABLE = 0;
    localparam int B_JUSTIFY = 7;
    localparam int B_CAL = 6;
    localparam int B_ACQ_HI = 5;
    localparam int B_ACQ_LO = 3;
    localparam int B_CLK_HI = 2;
    localparam int B_CLK_LO = 0;
    localparam int B_SHARED_SEL = 4;
    localparam int B_DONE_FLAG = 0;

    // ***********************************************************
    // Reset values and masks
    // ***********************************************************
    localparam logic [7:0] CTRL0_RST = 8'h00;
    localparam logic [7:0] CTRL1_RST = 8'h00;
    localparam logic [7:0] PIN_RST = 8'h00;
    // Implemented pin configuration bits
    localparam logic [7:0] PIN_LOW_MASK = 8'h9F;
    localparam logic [7:0] PIN_HIGH_MASK = 8'hFC;
    // Channels with an input on the wide and narrow package
    localparam logic [15:0] CHAN_WIDE_MASK = 16'hFC9F;
    localparam logic [15:0] CHAN_NARROW_MASK = 16'h0C9F;
    localparam logic [9:0] LFSR_SEED = 10'h001;

    // ***********************************************************
    // Conversion clock sources
    // ***********************************************************
    localparam logic [2:0] CLK_DIV2 = 3'h0;
    localparam logic [2:0] CLK_DIV8 = 3'h1;
    localparam logic [2:0] CLK_DIV32 = 3'h2;
    localparam logic [2:0] CLK_RC_A = 3'h3;
    localparam logic [2:0] CLK_DIV4 = 3'h4;
    localparam logic [2:0] CLK_DIV16 = 3'h5;
    localparam logic [2:0] CLK_DIV64 = 3'h6;
    localparam logic [2:0] CLK_RC_B = 3'h7;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_ACQ = 3'b010,
        ST_CONV = 3'b100
    } adcs_state_t;

    // Acquisition delay in conversion clock periods
    function automatic logic [4:0] adcs_acq_periods(input logic [2:0] code);
        logic [4:0] n;
        n = 5'h00;
        case (code)
            3'h0: n = 5'h00;
            3'h1: n = 5'h02;
            3'h2: n = 5'h04;
            3'h3: n = 5'h06;
            3'h4: n = 5'h08;
            3'h5: n = 5'h0C;
            3'h6: n = 5'h10;
            3'h7: n = 5'h14;
            default: n = 5'h00;
        endcase
        return n;
    endfunction : adcs_acq_periods

endpackage : adcs_pkg

// file: include/adcs_clk_if.sv
`timescale 1ns/1ps
// ***************************************************************
// Conversion clock request and tick
// ***************************************************************
interface adcs_clk_if;
    logic run;
    logic [2:0] sel;
    logic tick;

    modport gen (input run, input sel, output tick);
    modport user (output run, output sel, input tick);
endinterface : adcs_clk_if

// file: design/adcs_tick_gen.sv
`timescale 1ns/1ps
// ***************************************************************
// Conversion clock enable generator
// ***************************************************************
module adcs_tick_gen
    import adcs_pkg::*;
#(
    parameter int DIV_W = 7
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic rc_tick_i,
    adcs_clk_if.gen ck
);

    if (DIV_W < 7) begin : g_chk
        $error("adcs_tick_gen: DIV_W must reach a divide of 64");
    end

    logic [DIV_W-1:0] div_cnt_q;
    logic [DIV_W-1:0] div_last_w;
    logic [3:0] dly_cnt_q;
    logic is_rc_w;
    logic dly_done_w;
    logic tick_q;

    // Divide ratio minus one for the selected source
    assign is_rc_w = (ck.sel == CLK_RC_A) || (ck.sel == CLK_RC_B);
    assign div_last_w = (ck.sel == CLK_DIV2) ? DIV_W'(1) :
                        (ck.sel == CLK_DIV4) ? DIV_W'(3) :
                        (ck.sel == CLK_DIV8) ? DIV_W'(7) :
                        (ck.sel == CLK_DIV16) ? DIV_W'(15) :
                        (ck.sel == CLK_DIV32) ? DIV_W'(31) : DIV_W'(63);
    assign dly_done_w = (dly_cnt_q == 4'(INSTR_CLKS));
    assign ck.tick = tick_q;

    // Divider, held at zero while idle so each run starts aligned
    always_ff @(posedge clk_i) begin
        if (rst_i || !ck.run || div_cnt_q == div_last_w) begin
            div_cnt_q <= '0;
        end else begin
            div_cnt_q <= div_cnt_q + DIV_W'(1);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i || !ck.run) begin
            dly_cnt_q <= 4'h0;
        end else if (!dly_done_w) begin
            dly_cnt_q <= dly_cnt_q + 4'h1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i || !ck.run) begin
            tick_q <= 1'b0;
        end else if (is_rc_w) begin
            tick_q <= rc_tick_i && dly_done_w;
        end else begin
            tick_q <= (div_cnt_q == div_last_w);
        end
    end

    // no tick in first instruction cycle
    rc_delay_a: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(ck.run) && is_rc_w |-> !tick_q [*4])
        else $error("rc clock ticked before delay");

    div_gap_a: assert property (@(posedge clk_i) disable iff (rst_i)
        tick_q && !is_rc_w && $stable(ck.sel) |=> !tick_q)
        else $error("divided tick lasted two cycles");

endmodule : adcs_tick_gen

// file: design/adcs_top.sv
// Local design decisions: the Wishbone slave port and the register offsets.
`timescale 1ns/1ps
// Behaviour
// - Each conversion yields a ten bit result of the chosen input.
// - Channel field picks inputs 0-4, 7 and 10-15; other codes unused.
// - Channels 12-15 absent on small package; such conversions return junk.
// - Bit 7 picks external negative reference, else analog ground.
// - Bit 6 picks external positive reference, else analog supply.
// - Start bit reads one during conversion, zero when idle.
// - Enable bit switches the converter on and off.
// - Format bit picks right justify when one, left when zero.
// - Calibration bit makes the next started conversion a calibration.
// - Acquisition field sets delay of 0 to 20 conversion clocks.
// - Clock field picks oscillator divide or the internal RC clock.
// - RC clock waits one instruction cycle before running.
// - Set pin bit means digital; clear means analog, input reads zero.
// - Reset returns every shared pin to analog.
// - Bank select bit swaps control and pin registers on one address.
// - Completion loads result, clears start bit, sets done flag.
// - Acquisition delay runs between start and actual conversion.
// - Reset turns converter off, aborts conversion, keeps result.
module adcs_top
    import adcs_pkg::*;
#(
    parameter bit WIDE_PACKAGE = 1'b1
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic rc_tick_i,
    input wire logic core_done_i,
    input wire logic [9:0] core_result_i,
    output logic [3:0] channel_select_o,
    output logic neg_ref_select_o,
    output logic pos_ref_select_o,
    output logic converter_enable_o,
    output logic core_sample_o,
    output logic core_convert_o,
    output logic core_calibrate_o,
    output logic conv_clock_tick_o,
    output logic conversion_done_flag_o,
    output logic [15:0] pin_digital_select_o,
    input wire logic [15:0] pin_din_i,
    output logic [15:0] pin_din_o
);

    // ***********************************************************
    // Registers
    // ***********************************************************
    logic [7:0] ctrl0_q;
    logic [7:0] ctrl1_q;
    logic [7:0] pin_low_q;
    logic [7:0] pin_high_q;
    logic shared_sel_q;
    logic done_flag_q;
    logic [15:0] result_q;
    logic [31:0] rdata_q;
    logic ack_q;
    logic [15:0] pin_din_q;
    logic cal_q;
    logic tick_out_q;
    logic [9:0] lfsr_q;
    adcs_state_t state_q;
    adcs_state_t state_d;
    logic [4:0] acq_cnt_q;

    // ***********************************************************
    // Bus decode
    // ***********************************************************
    logic bus_req_w;
    logic wr_w;
    logic wr_ctrl0_w;
    logic wr_ctrl1_w;
    logic wr_pin_high_w;
    logic wr_pin_low_w;
    logic wr_wdt_w;
    logic wr_status_w;
    logic [7:0] rd_byte_w;
    logic [7:0] ctrl0_rd_w;
    logic start_go_w;

    // New request only once per handshake
    assign bus_req_w = wb_cyc_i && wb_stb_i && !ack_q;
    assign wr_w = bus_req_w && wb_we_i && wb_sel_i[0];
    assign wr_ctrl0_w = wr_w && (wb_adr_i == OFS_CTRL0) && !shared_sel_q;
    assign wr_pin_high_w = wr_w && (wb_adr_i == OFS_CTRL0) && shared_sel_q;
    assign wr_ctrl1_w = wr_w && (wb_adr_i == OFS_CTRL1) && !shared_sel_q;
    assign wr_pin_low_w = wr_w && (wb_adr_i == OFS_CTRL1) && shared_sel_q;
    assign wr_wdt_w = wr_w && (wb_adr_i == OFS_WDT_CTRL);
    assign wr_status_w = wr_w && (wb_adr_i == OFS_STATUS);

    // start bit shows conversion in progress
    assign ctrl0_rd_w = {ctrl0_q[7:2], (state_q != ST_IDLE), ctrl0_q[B_ENABLE]};

    // Read mux; unmapped offsets read zero
    assign rd_byte_w =
        (wb_adr_i == OFS_CTRL0) ? (shared_sel_q ? pin_high_q : ctrl0_rd_w) :
        (wb_adr_i == OFS_CTRL1) ? (shared_sel_q ? pin_low_q : ctrl1_q) :
        (wb_adr_i == OFS_RES_HIGH) ? result_q[15:8] :
        (wb_adr_i == OFS_RES_LOW) ? result_q[7:0] :
        (wb_adr_i == OFS_WDT_CTRL) ? {3'h0, shared_sel_q, 4'h0} :
        (wb_adr_i == OFS_STATUS) ? {7'h00, done_flag_q} : 8'h00;

    // start only honoured with the converter on
    assign start_go_w = wr_ctrl0_w && wb_dat_i[B_START] && wb_dat_i[B_ENABLE]
                        && (state_q == ST_IDLE);

    // Ack one cycle after the strobe, dropped the cycle after
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
        end else begin
            ack_q <= bus_req_w;
            rdata_q <= {24'h00_0000, rd_byte_w};
        end
    end

    // ***********************************************************
    // Control registers
    // ***********************************************************
    // control 0 fields, start bit not stored
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl0_q <= CTRL0_RST;
        end else if (wr_ctrl0_w) begin
            ctrl0_q <= {wb_dat_i[7:2], 1'b0, wb_dat_i[B_ENABLE]};
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl1_q <= CTRL1_RST;
        end else if (wr_ctrl1_w) begin
            ctrl1_q <= wb_dat_i[7:0];
        end
    end

    // pins back to analog on reset
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_low_q <= PIN_RST;
            pin_high_q <= PIN_RST;
            shared_sel_q <= 1'b0;
        end else begin
            if (wr_pin_low_w) begin
                pin_low_q <= wb_dat_i[7:0] & PIN_LOW_MASK;
            end
            if (wr_pin_high_w) begin
                pin_high_q <= wb_dat_i[7:0] & PIN_HIGH_MASK;
            end
            if (wr_wdt_w) begin
                shared_sel_q <= wb_dat_i[B_SHARED_SEL];
            end
        end
    end

    // analog pins read zero on their digital input
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_din_q <= 16'h0000;
        end else begin
            pin_din_q <= pin_din_i & {pin_high_q, pin_low_q};
        end
    end

    // ***********************************************************
    // Conversion sequencer
    // ***********************************************************
    logic [4:0] acq_len_w;
    logic [15:0] chan_mask_w;
    logic chan_ok_w;
    logic [9:0] raw_w;
    logic done_w;
    adcs_clk_if ck_if ();

    assign acq_len_w = adcs_acq_periods(ctrl1_q[B_ACQ_HI:B_ACQ_LO]);
    assign chan_mask_w = WIDE_PACKAGE ? CHAN_WIDE_MASK : CHAN_NARROW_MASK;
    assign chan_ok_w = chan_mask_w[ctrl0_q[B_CHAN_HI:B_CHAN_LO]];
    // absent channel gives a noise word
    assign raw_w = chan_ok_w ? core_result_i : lfsr_q;
    assign done_w = (state_q == ST_CONV) && core_done_i;
    assign ck_if.run = ctrl0_q[B_ENABLE] && (state_q != ST_IDLE);
    assign ck_if.sel = ctrl1_q[B_CLK_HI:B_CLK_LO];

    adcs_tick_gen u_tick (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .rc_tick_i(rc_tick_i),
        .ck(ck_if.gen)
    );

    // Next state; clearing enable aborts at once
    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: begin
                if (start_go_w) begin
                    state_d = ST_ACQ;
                end
            end
            // hold acquisition for the programmed delay
            ST_ACQ: begin
                if (acq_cnt_q == acq_len_w) begin
                    state_d = ST_CONV;
                end
            end
            ST_CONV: begin
                if (core_done_i) begin
                    state_d = ST_IDLE;
                end
            end
            default: state_d = ST_IDLE;
        endcase
        // disable stops any conversion; a start that also enables wins
        if (!ctrl0_q[B_ENABLE] && !start_go_w) begin
            state_d = ST_IDLE;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_q <= ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i || state_q != ST_ACQ) begin
            acq_cnt_q <= 5'h00;
        end else if (ck_if.tick && acq_cnt_q != acq_len_w) begin
            acq_cnt_q <= acq_cnt_q + 5'h01;
        end
    end

    // calibration latched when a conversion starts
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cal_q <= 1'b0;
            tick_out_q <= 1'b0;
            lfsr_q <= LFSR_SEED;
        end else begin
            if (start_go_w) begin
                cal_q <= ctrl1_q[B_CAL];
            end
            tick_out_q <= ck_if.tick;
            lfsr_q <= {lfsr_q[8:0], lfsr_q[9] ^ lfsr_q[6]};
        end
    end

    // result load; left alone by reset
    always_ff @(posedge clk_i) begin
        if (done_w && ctrl0_q[B_ENABLE]) begin
            result_q <= ctrl1_q[B_JUSTIFY] ? {6'h00, raw_w} : {raw_w, 6'h00};
        end
    end

    // done flag, set wins over a write-one clear
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            done_flag_q <= 1'b0;
        end else if (done_w && ctrl0_q[B_ENABLE]) begin
            done_flag_q <= 1'b1;
        end else if (wr_status_w && wb_dat_i[B_DONE_FLAG]) begin
            done_flag_q <= 1'b0;
        end
    end

    // ***********************************************************
    // Outputs
    // ***********************************************************
    assign wb_dat_o = rdata_q;
    assign wb_ack_o = ack_q;
    assign channel_select_o = ctrl0_q[B_CHAN_HI:B_CHAN_LO];
    assign neg_ref_select_o = ctrl0_q[B_NEG_REF];
    assign pos_ref_select_o = ctrl0_q[B_POS_REF];
    assign converter_enable_o = ctrl0_q[B_ENABLE];
    assign core_sample_o = state_q[1];
    assign core_convert_o = state_q[2];
    assign core_calibrate_o = cal_q;
    assign conv_clock_tick_o = tick_out_q;
    assign conversion_done_flag_o = done_flag_q;
    assign pin_digital_select_o = {pin_high_q, pin_low_q};
    assign pin_din_o = pin_din_q;

    // ***********************************************************
    // Checks
    // ***********************************************************
    // start write shows busy next cycle
    start_busy_a: assert property (@(posedge clk_i) disable iff (rst_i)
        start_go_w |=> wb_ack_o && ctrl0_rd_w[B_START] && core_sample_o)
        else $error("start did not show busy");

    // completion clears busy and sets flag
    done_load_a: assert property (@(posedge clk_i) disable iff (rst_i)
        done_w && ctrl0_q[B_ENABLE] |=> !ctrl0_rd_w[B_START] && done_flag_q)
        else $error("completion not reported");

    right_just_a: assert property (@(posedge clk_i) disable iff (rst_i)
        done_w && ctrl0_q[B_ENABLE] && ctrl1_q[B_JUSTIFY] && chan_ok_w
        |=> result_q == {6'h00, $past(core_result_i)})
        else $error("right justified result wrong");

    left_just_a: assert property (@(posedge clk_i) disable iff (rst_i)
        done_w && ctrl0_q[B_ENABLE] && !ctrl1_q[B_JUSTIFY] |=> result_q[5:0] == 6'h00)
        else $error("left justified result wrong");

    disable_abort_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !ctrl0_q[B_ENABLE] && !start_go_w |=> !core_sample_o && !core_convert_o)
        else $error("conversion ran while disabled");

    // conversion begins only after full delay
    acq_delay_a: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(core_convert_o) |-> $past(acq_cnt_q) == $past(acq_len_w))
        else $error("acquisition cut short");

    reset_pins_a: assert property (@(posedge clk_i)
        $fell(rst_i) |-> pin_digital_select_o == 16'h0000 && !converter_enable_o)
        else $error("reset left pins digital");

    pin_zero_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ##1 (pin_din_o == ($past(pin_din_i) & $past(pin_digital_select_o))))
        else $error("analog pin input not zero");

    // calibration follows the bit at start
    cal_start_a: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(core_sample_o) |-> core_calibrate_o == $past(ctrl1_q[B_CAL]))
        else $error("calibration request lost");

endmodule : adcs_top

// file: tb/adcs_core_model.sv
`timescale 1ns/1ps
// ***************************************************************
// Analog core stand-in
// ***************************************************************
module adcs_core_model (
    input wire logic clk_i,
    input wire logic convert_i,
    input wire logic [3:0] chan_i,
    output logic done_o,
    output logic [9:0] res_o
);
    logic [2:0] cnt_q = 3'h0;

    // Finish four cycles into a conversion, one pulse only
    always_ff @(posedge clk_i) begin
        cnt_q <= !convert_i ? 3'h0 : (cnt_q == 3'h4 ? cnt_q : cnt_q + 3'h1);
        done_o <= convert_i && cnt_q == 3'h3;
    end

    // ten bit result
    // Outside the result cycle the lines toggle, so stale data never matches
    always_ff @(posedge clk_i) begin
        res_o <= (convert_i && cnt_q == 3'h3) ? {chan_i, 6'h15} : ~res_o;
    end

    initial begin
        done_o = 1'b0;
        res_o = 10'h155;
    end
endmodule : adcs_core_model

// file: tb/test_adcs_top.sv
`timescale 1ns/1ps
module test_adcs_top;
    import adcs_pkg::*;
    logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, rc_tick = 0;
    logic [1:0] rcc = 2'h0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0, rdat;
    logic [15:0] din = 16'h0000, pins, pdin;
    logic [9:0] res;
    logic [3:0] chan;
    logic ack, done, neg, pos, en, smp, cnv, cal, tick, flag;
    int error_cnt = 0, cmp_count = 0;

    adcs_top dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .rc_tick_i(rc_tick), .core_done_i(done), .core_result_i(res),
        .channel_select_o(chan), .neg_ref_select_o(neg), .pos_ref_select_o(pos),
        .converter_enable_o(en), .core_sample_o(smp), .core_convert_o(cnv),
        .core_calibrate_o(cal), .conv_clock_tick_o(tick), .conversion_done_flag_o(flag),
        .pin_digital_select_o(pins), .pin_din_i(din), .pin_din_o(pdin));
    adcs_core_model core_u (.clk_i(clk_i), .convert_i(cnv), .chan_i(chan), .done_o(done),
        .res_o(res));

    initial begin
        forever #5 clk_i = ~clk_i;
    end

    // RC clock stand-in, one pulse every third cycle
    always @(posedge clk_i) begin
        rcc <= (rcc == 2'h2) ? 2'h0 : rcc + 2'h1;
        rc_tick <= (rcc == 2'h0);
    end

    // ***********************************************************
    // Shared tasks
    // ***********************************************************
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : tally_and_finish

    task automatic chk(input bit ok, input string m);
        cmp_count++;
        if (!ok) begin
            error_cnt++;
            $display("MISMATCH t=%0t %s", $time, m);
        end
    endtask : chk

    // One classic cycle, held until ack is seen at an edge
    task automatic wb(input bit w, input logic [7:0] a, input logic [7:0] d,
            output logic [7:0] q);
        int n;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= {24'h0, d};
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 20);
        if (ack !== 1'b1) begin
            error_cnt++;
            tally_and_finish();
        end
        q = rdat[7:0];
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask : wb

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] q;
        wb(1'b1, a, d, q);
    endtask : wr

    task automatic rdc(input logic [7:0] a, input logic [7:0] e, input string m);
        logic [7:0] q;
        wb(1'b0, a, 8'h00, q);
        chk(q === e, m);
    endtask : rdc

    task automatic do_reset;
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
    endtask : do_reset

    // ***********************************************************
    // Scenarios
    // ***********************************************************
    task automatic t_fields;
        rdc(OFS_CTRL0, 8'h00, "ctrl0 reset");
        rdc(OFS_CTRL1, 8'h00, "ctrl1 reset");
        chk(pins === 16'h0000 && flag === 1'b0, "pins reset");
        wr(OFS_CTRL0, 8'hA8);
        chk(neg === 1'b1 && pos === 1'b0 && chan === 4'hA && en === 1'b0, "fields");
        wr(OFS_CTRL0, 8'h5C);
        chk(neg === 1'b0 && pos === 1'b1 && chan === 4'h7, "fields");
        rdc(8'h20, 8'h00, "unmapped");
        $display("fields done");
    endtask : t_fields

    task automatic conv(input logic [7:0] c1, input logic [3:0] ch, input bit ok);
        logic [7:0] h, l;
        logic [15:0] e;
        int n, s, na, k;
        bit cs;
        na = (c1[5:3] < 3'h5) ? 2 * c1[5:3] : 4 * c1[5:3] - 8;
        wr(OFS_CTRL1, c1);
        wr(OFS_CTRL0, {2'b10, ch, 2'b11});
        rdc(OFS_CTRL0, {2'b10, ch, 2'b11}, "busy set");
        n = 0;
        s = 0;
        k = 0;
        cs = 1'b0;
        while (flag !== 1'b1 && n < 3000) begin
            @(posedge clk_i);
            n++;
            s += (smp === 1'b1);
            k += (tick === 1'b1);
            if (cnv === 1'b1) cs = cal;
        end
        chk(flag === 1'b1, "no completion");
        if (c1[2:0] == 3'h0) chk(s >= 2 * na - 3 && s <= 2 * na + 4, "acq length");
        if (c1[2:0] == 3'h0) chk(k >= na - 3 && k <= na + 4, "tick count");
        chk(cs === c1[6], "calibrate");
        rdc(OFS_CTRL0, {2'b10, ch, 2'b01}, "busy clear");
        wb(1'b0, OFS_RES_HIGH, 8'h00, h);
        wb(1'b0, OFS_RES_LOW, 8'h00, l);
        e = c1[7] ? {6'h00, ch, 6'h15} : {ch, 6'h15, 6'h00};
        if (ok) chk({h, l} === e, "result");
        wr(OFS_STATUS, 8'h01);
        chk(flag === 1'b0, "flag clear");
        // Gap of two slowest conversion clocks before the next start
        repeat (130) @(posedge clk_i);
    endtask : conv

    task automatic t_pins;
        wr(OFS_WDT_CTRL, 8'h10);
        wr(OFS_CTRL0, 8'hFF);
        wr(OFS_CTRL1, 8'hFF);
        rdc(OFS_CTRL0, 8'hFC, "pin high");
        rdc(OFS_CTRL1, 8'h9F, "pin low");
        din <= 16'hFFFF;
        repeat (3) @(posedge clk_i);
        chk(pins === 16'hFC9F && pdin === 16'hFC9F, "digital pins");
        wr(OFS_WDT_CTRL, 8'h00);
        rdc(OFS_CTRL1, 8'h38, "bank back");
        do_reset();
        repeat (2) @(posedge clk_i);
        chk(pins === 16'h0000 && pdin === 16'h0000, "pins analog");
        rdc(OFS_RES_HIGH, 8'hA5, "result kept");
        $display("pins done");
    endtask : t_pins

    task automatic t_abort;
        wr(OFS_CTRL1, 8'h3E);
        wr(OFS_CTRL0, 8'h03);
        repeat (20) @(posedge clk_i);
        wr(OFS_CTRL0, 8'h00);
        repeat (3) @(posedge clk_i);
        chk(en === 1'b0 && smp === 1'b0 && cnv === 1'b0, "abort");
        chk(flag === 1'b0, "no flag");
        $display("abort done");
    endtask : t_abort

    initial begin
        logic [3:0] chs [8] = '{4'h0, 4'h4, 4'h7, 4'hA, 4'hF, 4'h2, 4'h5, 4'hD};
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        t_fields();
        // Every clock source and acquisition code once
        for (int i = 0; i < 8; i++) begin
            conv({i[0], i == 5, i[2:0], ~i[2:0]}, chs[i], i != 5 && i != 6);
        end
        $display("conversions done");
        wr(OFS_CTRL1, 8'hB8);
        conv(8'h38, 4'hA, 1'b1);
        t_pins();
        t_abort();
        tally_and_finish();
    end
endmodule : test_adcs_top
